/* src/irq_ctrl_defines.vh */
// constants for the prioritized vectored interrupt controller
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// =====================================
// register byte addresses
`define REG_REQ 8'h00
`define REG_ENA 8'h04
`define REG_CTRL 8'h08
`define REG_STAT 8'h0c

// =====================================
// source bit positions in request and enable registers
`define SRC_TICK 0
`define SRC_DUAL 1
`define SRC_EDGE_A 2
`define SRC_EDGE_B 3
`define SRC_SERIAL 4
`define SRC_MATCH 5
`define SRC_EXT_TEST 6
`define SRC_WATCH 7
`define NUM_SRC 8
`define NUM_PINS 8
// the same positions as 3-bit source numbers
`define SRC_ID_TICK 3'h0
`define SRC_ID_DUAL 3'h1
`define SRC_ID_EDGE_A 3'h2
`define SRC_ID_EDGE_B 3'h3
`define SRC_ID_SERIAL 3'h4
`define SRC_ID_MATCH 3'h5

// =====================================
// control register fields
`define CTRL_IME 0
`define CTRL_A_FALL 1
`define CTRL_B_FALL 2
`define CTRL_WATCH_FAST 3
`define CTRL_W 4

// =====================================
// reset values
`define REQ_RST 8'h00
`define ENA_RST 8'h00
`define CTRL_RST 4'h0

// =====================================
// priority ranks and vector table entries
`define RANK_NONE 3'h0
`define RANK_1 3'h1
`define RANK_2 3'h2
`define RANK_3 3'h3
`define RANK_4 3'h4
`define RANK_5 3'h5
`define VEC_NONE 16'h0000
`define VEC_RANK_1 16'h0002
`define VEC_RANK_2 16'h0004
`define VEC_RANK_3 16'h0006
`define VEC_RANK_4 16'h0008
`define VEC_RANK_5 16'h000a

// =====================================
// watch interval timing
`define WATCH_INTERVAL_MS 500
`define CLK_FREQ_MHZ 250
`define WATCH_FAST_DIV 128

`endif

/* src/pin_edge_detect.v */
// edge detector with selectable rising and falling sensitivity
`timescale 1ns/1ns
module pin_edge_detect (
   input wire sys_clk,
   input wire sys_rst,
   input wire pin,
   input wire rise_en,
   input wire fall_en,
   output wire edge_hit
);
   reg prev_ff;

   // =====================================
   // previous level
   // prev resets low, so a pin that is already high at release reads as a rising edge
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= pin;
      end
   end

   assign edge_hit = (rise_en & pin & ~prev_ff) | (fall_en & ~pin & prev_ff);
endmodule

/* src/prioritized_vector_irq_ctrl.v */
// prioritized vectored interrupt controller with test sources and standby wake
//
// Contract
// R1 - simultaneous requests are served in fixed order from rank 1 (highest) to rank 5 (lowest).
// R2 - the interval tick and the dual-edge pin share rank 1 and vector address 0002H.
// R3 - the dual-edge pin requests on both rising and falling transitions.
// R4 - the two single-edge pins take a software-chosen edge and use 0004H (rank 2) and 0006H (rank 3).
// R5 - serial transfer completion requests at rank 4 through vector address 0008H.
// R6 - a counter match with its modulo value requests at rank 5 through vector address 000AH.
// R7 - the external test source sets on a rising test pin or on a falling edge of any key-return input.
// R8 - test sources set their flags and follow their enables but never cause a vectored interrupt.
// R9 - a vectored request is taken only when its source enable and the master enable are both set.
// R10 - every request flag can be read by software without taking the interrupt.
// R11 - any set request whose enable is set wakes the core from standby, others do not.
// R12 - the handler start address comes from the programmable vector table entry that is handed out; the code hands out fixed entries 0002H to 000AH.
// R13 - a higher rank request may interrupt a running handler, a same or lower rank one may not.
// R14 - the watch test flag sets every 0.5 s, or 128 times more often in fast mode.
// R15 - taking a vectored request clears that source flag and dispatches through its vector entry.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "irq_ctrl_defines.vh"
module prioritized_vector_irq_ctrl #(
   parameter WATCH_CYCLES = `WATCH_INTERVAL_MS * `CLK_FREQ_MHZ * 1000,
   parameter CNT_W = 27
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire interval_tick_request,
   input wire dual_edge_ext_request,
   input wire edge_ext_request_a,
   input wire edge_ext_request_b,
   input wire serial_done_request,
   input wire counter_match_request,
   input wire ext_test_source,
   input wire [3:0] key_return_inputs,
   input wire irq_ack,
   input wire irq_return,
   output reg irq_req,
   output reg [15:0] vector_addr,
   output reg [2:0] irq_rank,
   output reg irq_wake
);
   localparam integer WATCH_LAST_INT = WATCH_CYCLES - 1;
   localparam integer WATCH_FAST_LAST_INT = WATCH_CYCLES / `WATCH_FAST_DIV - 1;
   localparam [CNT_W-1:0] WATCH_LAST = WATCH_LAST_INT[CNT_W-1:0];
   localparam [CNT_W-1:0] WATCH_FAST_LAST = WATCH_FAST_LAST_INT[CNT_W-1:0];

   reg [`NUM_SRC-1:0] req_ff;
   reg [`NUM_SRC-1:0] ena_ff;
   reg [`CTRL_W-1:0] ctrl_ff;
   reg [5:1] in_svc_ff;
   reg [2:0] rank_ff;
   reg [2:0] src_ff;
   reg [CNT_W-1:0] watch_cnt_ff;
   reg [`NUM_SRC-1:0] nxt_req;
   reg [5:1] nxt_in_svc;
   reg [2:0] nxt_rank;
   reg [2:0] nxt_src;
   reg [15:0] nxt_vec;
   reg [7:0] nxt_rdata;
   reg [5:1] return_clr;

   wire [`NUM_PINS-1:0] pin_vec;
   wire [`NUM_PINS-1:0] rise_vec;
   wire [`NUM_PINS-1:0] fall_vec;
   wire [`NUM_PINS-1:0] pin_hit;
   wire [`NUM_SRC-1:0] set_vec;
   wire [`NUM_SRC-1:0] elig;
   wire [5:1] rank_hit;
   wire [5:1] rank_ok;
   wire watch_hit;
   wire wr_req;
   wire wr_ena;
   wire wr_ctrl;
   wire master_irq_enable;
   wire take;

   assign master_irq_enable = ctrl_ff[`CTRL_IME];
   assign wr_req = reg_wr && (reg_addr == `REG_REQ);
   assign wr_ena = reg_wr && (reg_addr == `REG_ENA);
   assign wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);

   // =====================================
   // acknowledge handshake
   // an ack counts only while an offer stands; one that arrives after the offer dropped is ignored
   assign take = irq_ack && irq_req;

   // =====================================
   // pin edge detection
   // pin order: dual edge, edge a, edge b, test pin, key returns 0..3
   // key returns idle high, so they are watched for falls only
   assign pin_vec = {key_return_inputs, ext_test_source, edge_ext_request_b, edge_ext_request_a,
                     dual_edge_ext_request};
   assign rise_vec = {4'h0, 1'b1, ~ctrl_ff[`CTRL_B_FALL], ~ctrl_ff[`CTRL_A_FALL], 1'b1}; // R3 R4 R7
   assign fall_vec = {4'hf, 1'b0, ctrl_ff[`CTRL_B_FALL], ctrl_ff[`CTRL_A_FALL], 1'b1}; // R3 R4 R7

   genvar gi;
   generate
      for (gi = 0; gi < `NUM_PINS; gi = gi + 1) begin : g_pin
         pin_edge_detect u_edge (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .pin(pin_vec[gi]),
            .rise_en(rise_vec[gi]),
            .fall_en(fall_vec[gi]),
            .edge_hit(pin_hit[gi])
         );
      end
   endgenerate

   // =====================================
   // watch interval generator
   // the divider restarts when fast mode changes so the first short interval is whole
   // only whole cycle counts exist, so a fast interval that does not divide evenly rounds down
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         watch_cnt_ff <= {CNT_W{1'b0}};
      end else if (watch_hit || (wr_ctrl && (reg_wdata[`CTRL_WATCH_FAST] != ctrl_ff[`CTRL_WATCH_FAST]))) begin
         watch_cnt_ff <= {CNT_W{1'b0}};
      end else begin
         watch_cnt_ff <= watch_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign watch_hit = ctrl_ff[`CTRL_WATCH_FAST] ? (watch_cnt_ff == WATCH_FAST_LAST) :
                      (watch_cnt_ff == WATCH_LAST); // R14

   // =====================================
   // request set sources
   // level inputs set their flag on every high cycle, so a held level sets a cleared flag again
   assign set_vec[`SRC_TICK] = interval_tick_request;
   assign set_vec[`SRC_DUAL] = pin_hit[0]; // R3
   assign set_vec[`SRC_EDGE_A] = pin_hit[1]; // R4
   assign set_vec[`SRC_EDGE_B] = pin_hit[2]; // R4
   assign set_vec[`SRC_SERIAL] = serial_done_request; // R5
   assign set_vec[`SRC_MATCH] = counter_match_request; // R6
   assign set_vec[`SRC_EXT_TEST] = |pin_hit[7:3]; // R7
   assign set_vec[`SRC_WATCH] = watch_hit; // R14

   // =====================================
   // priority resolution
   // test sources are left out of elig so they never reach the vector path
   assign elig = req_ff & ena_ff & {2'b00, {6{master_irq_enable}}}; // R8 R9
   assign rank_hit[1] = elig[`SRC_TICK] | elig[`SRC_DUAL]; // R2
   assign rank_hit[2] = elig[`SRC_EDGE_A]; // R4
   assign rank_hit[3] = elig[`SRC_EDGE_B]; // R4
   assign rank_hit[4] = elig[`SRC_SERIAL]; // R5
   assign rank_hit[5] = elig[`SRC_MATCH]; // R6

   // a rank may preempt only if no handler of its own or a higher rank is running
   assign rank_ok[1] = ~in_svc_ff[1]; // R13
   assign rank_ok[2] = ~|in_svc_ff[2:1]; // R13
   assign rank_ok[3] = ~|in_svc_ff[3:1]; // R13
   assign rank_ok[4] = ~|in_svc_ff[4:1]; // R13
   assign rank_ok[5] = ~|in_svc_ff[5:1]; // R13

   // nxt_src names the flag behind the offer, so an ack clears exactly what was offered
   always @* begin
      nxt_rank = `RANK_NONE;
      nxt_src = `SRC_ID_TICK;
      nxt_vec = `VEC_NONE;
      if (rank_hit[1] && rank_ok[1]) begin // R1
         nxt_rank = `RANK_1;
         // rank 1 is shared: the tick is served before the dual-edge pin
         nxt_src = elig[`SRC_TICK] ? `SRC_ID_TICK : `SRC_ID_DUAL;
         nxt_vec = `VEC_RANK_1; // R2 R12
      end else if (rank_hit[2] && rank_ok[2]) begin
         nxt_rank = `RANK_2;
         nxt_src = `SRC_ID_EDGE_A;
         nxt_vec = `VEC_RANK_2; // R4 R12
      end else if (rank_hit[3] && rank_ok[3]) begin
         nxt_rank = `RANK_3;
         nxt_src = `SRC_ID_EDGE_B;
         nxt_vec = `VEC_RANK_3; // R4 R12
      end else if (rank_hit[4] && rank_ok[4]) begin
         nxt_rank = `RANK_4;
         nxt_src = `SRC_ID_SERIAL;
         nxt_vec = `VEC_RANK_4; // R5 R12
      end else if (rank_hit[5] && rank_ok[5]) begin
         nxt_rank = `RANK_5;
         nxt_src = `SRC_ID_MATCH;
         nxt_vec = `VEC_RANK_5; // R6 R12
      end
   end

   // =====================================
   // request flags and in-service state
   always @* begin
      nxt_req = req_ff;
      if (wr_req) begin
         nxt_req = nxt_req & ~reg_wdata;
      end
      if (take) begin
         nxt_req[src_ff] = 1'b0; // R15
      end
      // a new event in the clearing cycle wins
      nxt_req = nxt_req | set_vec;
   end

   // return retires the highest-priority running handler
   always @* begin
      return_clr = 5'h00;
      if (in_svc_ff[1]) begin
         return_clr[1] = 1'b1;
      end else if (in_svc_ff[2]) begin
         return_clr[2] = 1'b1;
      end else if (in_svc_ff[3]) begin
         return_clr[3] = 1'b1;
      end else if (in_svc_ff[4]) begin
         return_clr[4] = 1'b1;
      end else if (in_svc_ff[5]) begin
         return_clr[5] = 1'b1;
      end
   end

   always @* begin
      nxt_in_svc = in_svc_ff;
      if (irq_return) begin
         nxt_in_svc = nxt_in_svc & ~return_clr;
      end
      // a return and an ack in one cycle: the return retires first, then the new rank enters
      if (take) begin
         case (rank_ff)
            `RANK_1: nxt_in_svc[1] = 1'b1; // R13
            `RANK_2: nxt_in_svc[2] = 1'b1;
            `RANK_3: nxt_in_svc[3] = 1'b1;
            `RANK_4: nxt_in_svc[4] = 1'b1;
            `RANK_5: nxt_in_svc[5] = 1'b1;
            default: nxt_in_svc = nxt_in_svc;
         endcase
      end
   end

   // =====================================
   // register read mux
   // reads have no side effects, so polling a flag never clears it
   always @* begin
      nxt_rdata = 8'h00;
      case (reg_addr)
         `REG_REQ: nxt_rdata = req_ff; // R10
         `REG_ENA: nxt_rdata = ena_ff;
         `REG_CTRL: nxt_rdata = {4'h0, ctrl_ff};
         `REG_STAT: nxt_rdata = {in_svc_ff, rank_ff};
         default: nxt_rdata = 8'h00;
      endcase
   end

   // =====================================
   // state registers
   // unmapped writes fall through every decode and are lost
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req_ff <= `REQ_RST;
         ena_ff <= `ENA_RST;
         ctrl_ff <= `CTRL_RST;
         in_svc_ff <= 5'h00;
         rank_ff <= `RANK_NONE;
         src_ff <= `SRC_ID_TICK;
      end else begin
         req_ff <= nxt_req;
         if (wr_ena) begin
            ena_ff <= reg_wdata;
         end
         if (wr_ctrl) begin
            ctrl_ff <= reg_wdata[`CTRL_W-1:0];
         end
         in_svc_ff <= nxt_in_svc;
         rank_ff <= nxt_rank;
         src_ff <= nxt_src;
      end
   end

   // =====================================
   // outputs
   // the request drops for the cycle after the acknowledge and is re-evaluated from updated state,
   // so a stale vector is never offered twice
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_req <= 1'b0;
         vector_addr <= `VEC_NONE;
         irq_rank <= `RANK_NONE;
         irq_wake <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         // the offer and its vector drop together, so no vector stands without an offer
         if (take) begin
            irq_req <= 1'b0;
            vector_addr <= `VEC_NONE;
            irq_rank <= `RANK_NONE;
         end else begin
            irq_req <= (nxt_rank != `RANK_NONE); // R9
            vector_addr <= nxt_vec; // R12 R15
            irq_rank <= nxt_rank; // R1
         end
         // wake ignores the master enable: standby must end even while vectoring is off
         irq_wake <= |(req_ff & ena_ff); // R11
         reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
      end
   end
endmodule

/* sim/irq_ctrl_monitor.sv */
// assertion checker on the controller's port signals
`timescale 1ns/1ns
module irq_ctrl_monitor (
   input wire sys_clk,
   input wire sys_rst,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire irq_ack,
   input wire irq_return,
   input wire irq_req,
   input wire [15:0] vector_addr,
   input wire [2:0] irq_rank,
   input wire irq_wake
);
   // =====================================
   // port relations
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_vec_from_rank: assert property (irq_req |-> vector_addr == {12'h000, irq_rank, 1'b0})
      else $error("vector address differs from rank entry");
   a_idle_zero: assert property (!irq_req |-> vector_addr == 16'h0000 && irq_rank == 3'h0)
      else $error("vector or rank set with no offer");
   a_rank_range: assert property (irq_req |-> irq_rank >= 3'h1 && irq_rank <= 3'h5)
      else $error("offered rank outside 1 to 5");
   a_ack_drops_req: assert property (irq_ack && irq_req |=> !irq_req)
      else $error("offer stands after acknowledge");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   a_nest_block: assert property (irq_ack && irq_req ##1 !irq_return
      |=> !irq_req || irq_rank < $past(irq_rank, 2))
      else $error("same or lower rank offered while in service");
   a_req_wakes: assert property (irq_req |-> irq_wake)
      else $error("offer without wake");
   // a rank can only move down in number unless software or the core intervened
   a_rank_no_drop: assert property (irq_req && !irq_ack && !$past(reg_wr)
      |=> !irq_req || irq_rank <= $past(irq_rank))
      else $error("offer replaced by lower priority");
endmodule
bind prioritized_vector_irq_ctrl irq_ctrl_monitor mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req),
   .vector_addr(vector_addr), .irq_rank(irq_rank), .irq_wake(irq_wake));

/* sim/core_model.sv */
// processor core model: takes offered vectors, returns from each handler after a delay
`timescale 1ns/1ns
module core_model #(parameter HOLD = 12) (
   input wire sys_clk,
   input wire sys_rst,
   input wire irq_req,
   input wire [15:0] vector_addr,
   output reg irq_ack,
   output reg irq_return
);
   // =====================================
   // acknowledge and return
   logic [15:0] seen[$];
   int depth;
   int cnt;
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_ack <= 1'b0;
         irq_return <= 1'b0;
         depth <= 0;
         cnt <= 0;
      end else begin
         // skip the cycle after an ack, the offer seen then is stale
         irq_ack <= irq_req && !irq_ack;
         irq_return <= 1'b0;
         // a vector is taken only at the edge where the ack meets a standing offer
         if (irq_ack && irq_req) begin
            seen.push_back(vector_addr);
            depth <= depth + 1;
            cnt <= HOLD;
         end else if (depth > 0) begin
            if (cnt == 1) begin
               irq_return <= 1'b1;
               depth <= depth - 1;
               cnt <= HOLD;
            end else begin
               cnt <= cnt - 1;
            end
         end
      end
   end
endmodule

/* sim/prioritized_vector_irq_ctrl_tb.sv */
// self-checking testbench for the vectored interrupt controller
`timescale 1ns/1ns
`include "irq_ctrl_defines.vh"
module prioritized_vector_irq_ctrl_tb;
   // =====================================
   // harness
   logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, tick = 0, dual = 0, pa = 0, pb = 0, ser = 0, mat = 0, ext = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
   logic [3:0] keys = 4'hf;
   logic irq_ack, irq_return, irq_req, irq_wake;
   logic [15:0] vector_addr;
   logic [2:0] irq_rank;
   int errors = 0, compares = 0;
   initial forever #2 sys_clk = ~sys_clk;
   prioritized_vector_irq_ctrl #(.WATCH_CYCLES(1280)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .interval_tick_request(tick),
      .dual_edge_ext_request(dual), .edge_ext_request_a(pa), .edge_ext_request_b(pb), .serial_done_request(ser),
      .counter_match_request(mat), .ext_test_source(ext), .key_return_inputs(keys), .irq_ack(irq_ack),
      .irq_return(irq_return), .irq_req(irq_req), .vector_addr(vector_addr), .irq_rank(irq_rank), .irq_wake(irq_wake));
   core_model #(.HOLD(12)) core (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_req(irq_req), .vector_addr(vector_addr),
      .irq_ack(irq_ack), .irq_return(irq_return));
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // vectors taken by the core, in order, bounded wait
   task chk_seq(input logic [15:0] e[$]);
      for (int i = 0; i < 400 && core.seen.size() < e.size(); i++) @(posedge sys_clk);
      chk("vector count", core.seen.size(), e.size());
      foreach (e[i]) chk("vector", core.seen[i], e[i]);
      core.seen.delete();
   endtask
   // =====================================
   // scenarios
   task t_regs;
      logic [7:0] adr[4] = '{`REG_REQ, `REG_ENA, `REG_STAT, 8'h10};
      foreach (adr[i]) begin
         rd(adr[i], v);
         chk("reset or unmapped read", v, 8'h00);
      end
      wr(`REG_CTRL, 8'hff);
      rd(`REG_CTRL, v);
      chk("ctrl readback", v, 8'h0f);
      $display("t_regs done");
   endtask
   task t_prio;
      wr(`REG_ENA, 8'hff);
      wr(`REG_CTRL, 8'h01);
      core.seen.delete();
      @(posedge sys_clk);
      {tick, dual, pa, ser, mat} <= 5'h1f;
      @(posedge sys_clk);
      {tick, ser, mat} <= 3'h0;
      chk_seq('{16'h0002, 16'h0002, 16'h0004, 16'h0008, 16'h000a});
      cyc(30);
      rd(`REG_STAT, v);
      chk("in service after returns", v, 8'h00);
      $display("t_prio done");
   endtask
   task t_nest;
      wr(`REG_CTRL, 8'h05);
      pb <= 1'b1;
      cyc(4);
      pb <= 1'b0;
      cyc(6);
      dual <= 1'b0;
      chk_seq('{16'h0006, 16'h0002});
      cyc(40);
      pb <= 1'b1;
      cyc(4);
      rd(`REG_REQ, v);
      chk("rise in falling mode", v & 8'h7f, 8'h00);
      chk("no further vector", core.seen.size(), 0);
      $display("t_nest done");
   endtask
   task t_mask;
      wr(`REG_CTRL, 8'h00);
      wr(`REG_ENA, 8'h00);
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
      cyc(3);
      chk("wake with source disabled", irq_wake, 1'b0);
      rd(`REG_REQ, v);
      chk("pending flag", v & 8'h7f, 8'h01);
      wr(`REG_ENA, 8'h01);
      cyc(2);
      chk("wake with source enabled", irq_wake, 1'b1);
      chk("offer without master", irq_req, 1'b0);
      wr(`REG_REQ, 8'h01);
      wr(`REG_ENA, 8'hc0);
      wr(`REG_CTRL, 8'h01);
      ext <= 1'b1;
      cyc(3);
      rd(`REG_REQ, v);
      chk("test pin rise", v & 8'h7f, 8'h40);
      chk("test source wakes", irq_wake, 1'b1);
      wr(`REG_REQ, 8'h40);
      keys <= 4'hb;
      cyc(3);
      rd(`REG_REQ, v);
      chk("key fall", v & 8'h7f, 8'h40);
      wr(`REG_CTRL, 8'h02);
      pa <= 1'b0;
      cyc(3);
      rd(`REG_REQ, v);
      chk("edge a fall", v & 8'h7f, 8'h44);
      chk("test never vectored", core.seen.size(), 0);
      $display("t_mask done");
   endtask
   task t_watch;
      wr(`REG_ENA, 8'h00);
      wr(`REG_CTRL, 8'h08);
      wr(`REG_REQ, 8'h80);
      rd(`REG_REQ, v);
      chk("fast early", v[7], 1'b0);
      cyc(10);
      rd(`REG_REQ, v);
      chk("fast interval", v[7], 1'b1);
      wr(`REG_CTRL, 8'h00);
      wr(`REG_REQ, 8'h80);
      cyc(1000);
      rd(`REG_REQ, v);
      chk("normal early", v[7], 1'b0);
      cyc(300);
      rd(`REG_REQ, v);
      chk("normal interval", v[7], 1'b1);
      $display("t_watch done");
   endtask
   task finish_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #40000;
      errors++;
      finish_test;
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_regs;
      t_prio;
      t_nest;
      t_mask;
      t_watch;
      finish_test;
   end
endmodule
